// ### hdl/iav_interrupt_ack_vectoring.sv
// Interrupt acknowledge and vectoring: acknowledge reads, encoded level, NMI.
// Assumes all inputs synchronous to i_clk; 56 sources as 7 levels x 8 priorities.
// Summary of operation
// R1 - Eight read-only acknowledge registers, by register read or enabled acknowledge cycle.
// R2 - Level acknowledge returns vector of highest priority active request in level.
// R3 - No active request at that level returns spurious vector 24.
// R4 - Acknowledge served wholly here; peripheral is never touched.
// R5 - Handler must clear the request in the peripheral itself.
// R6 - Software acknowledge returns highest level, highest priority vector, else zero.
// R7 - Acknowledge data eight bits: bit 7 zero, bits 6-0 vector.
// R8 - Levels one to six maskable level-sensitive; level seven non-maskable edge.
// R9 - Drive 3-bit encoded level; NMI each time level becomes seven.
// R10 - NMI also when mask drops from seven while level stays seven.
// R11 - Reset enables default mappings and clears forced request bits.
// R12 - Wake-up control disabled after reset; software programs it before stop.
// R13 - From reset, requests evaluated every cycle into level and vectors.
// R14 - No interrupt sampling during a handler's first instruction.
// R15 - With auto-mask set, mask loads seven on each interrupt exception.
// R16 - Software should use only mask values zero and seven.
// R17 - Store-load status instruction saves current mask and loads new one.
// R18 - Wake-up asserted when enabled and request level exceeds wake mask.
// R19 - Acknowledge read answers next cycle with state of the read cycle.
// R20 - Acknowledge reads never change request state.
`include "iav_regs.svh"

module iav_interrupt_ack_vectoring
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [55:0] i_irq,
  input wire logic [6:0] i_frc_set,
  input wire logic [6:0] i_frc_clr,
  input wire logic i_wcr_wr,
  input wire logic [7:0] i_wcr_wdata,
  input wire logic i_ack_rd,
  input wire logic [2:0] i_ack_sel,
  input wire logic i_iack_cycle,
  input wire logic [2:0] i_iack_level,
  input wire logic i_ack_cycle_enable_bit,
  input wire logic i_auto_mask_on_exception_bit,
  input wire logic [2:0] i_processor_mask_field,
  input wire logic i_exception_entry,
  input wire logic i_handler_first_instr,
  input wire logic i_store_load_status_instr,
  output logic [7:0] o_ack_data,
  output logic o_ack_valid,
  output logic [2:0] o_irq_level,
  output logic o_nmi,
  output logic o_int_take,
  output logic o_mask_load_seven,
  output logic [2:0] o_saved_mask,
  output logic o_wakeup,
  output logic [7:0] o_wakeup_control_reg,
  output logic [6:0] o_forced_request_reg
);

  // Highest set priority within one level; priority 7 wins
  function automatic logic [2:0] iav_top_prio(input logic [7:0] req);
    logic [2:0] p;
    p = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (req[i])
      begin
        p = 3'(i);
      end
    end
    return p;
  endfunction : iav_top_prio

  logic [6:0] frc_q;
  logic [7:0] wcr_q;
  logic [2:0] level_q;
  logic [2:0] mask_q;
  logic [7:0] ack_data_q;
  logic ack_valid_q;
  logic nmi_q;
  logic take_q;
  logic load7_q;
  logic [2:0] saved_q;
  logic wake_q;
  iav_pkg::iav_nmi_state_t nmi_state_q;
  iav_pkg::iav_nmi_state_t nmi_state_d;

  logic [7:1] lvl_any;
  iav_pkg::iav_vec_t lvl_vec [7:1];
  iav_pkg::iav_level_t level_d;
  iav_pkg::iav_vec_t sw_vec;
  logic ack_go;
  logic [2:0] ack_sel;
  iav_pkg::iav_vec_t ack_vec;
  logic nmi_event;
  logic can_sample;
  logic take_d;

  // Per-level winner: forced request first, then highest priority source
  generate
    for (genvar l = 1; l <= 7; l++)
    begin : g_level
      logic [7:0] req;
      assign req = i_irq[(l - 1) * 8 +: 8];
      assign lvl_any[l] = (|req) | frc_q[l - 1]; // R2 R13
      always_comb
      begin
        if (frc_q[l - 1])
        begin
          lvl_vec[l] = `IAV_VEC_FORCE_L7 + 7'(7 - l);
        end
        else
        begin
          lvl_vec[l] = `IAV_VEC_SRC_BASE + {1'b0, 3'(l - 1), iav_top_prio(req)}; // R2
        end
      end
    end
  endgenerate

  // Encoded request level and software acknowledge vector
  always_comb
  begin
    level_d = `IAV_LEVEL_NONE;
    sw_vec = `IAV_VEC_NONE;
    for (int l = 1; l <= 7; l++)
    begin
      if (lvl_any[l])
      begin
        level_d = 3'(l); // R9 R13
        sw_vec = lvl_vec[l]; // R6
      end
    end
  end

  // Register read and enabled acknowledge cycle take the same path
  always_comb
  begin
    ack_go = i_ack_rd | (i_iack_cycle & i_ack_cycle_enable_bit); // R1
    ack_sel = (i_iack_cycle & i_ack_cycle_enable_bit) ? i_iack_level : i_ack_sel; // R1
    if (ack_sel == `IAV_SEL_SOFTWARE)
    begin
      ack_vec = sw_vec; // R6
    end
    else if (lvl_any[ack_sel])
    begin
      ack_vec = lvl_vec[ack_sel]; // R2
    end
    else
    begin
      ack_vec = `IAV_VEC_SPURIOUS; // R3
    end
  end

  // Answer from internal state only; request state is not touched
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ack_data_q <= 8'h00;
      ack_valid_q <= 1'b0;
    end
    else
    begin
      ack_valid_q <= ack_go; // R19 R4 R20
      if (ack_go)
      begin
        ack_data_q <= {1'b0, ack_vec}; // R7 R19
      end
    end
  end

  // Forced request bits; set wins over clear
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      frc_q <= `IAV_FRC_RESET; // R11
    end
    else
    begin
      frc_q <= (frc_q & ~i_frc_clr) | i_frc_set;
    end
  end

  // Wake-up control register; mask held to 0..6
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wcr_q <= `IAV_WCR_RESET; // R12
    end
    else if (i_wcr_wr)
    begin
      wcr_q[`IAV_WCR_EN_BIT] <= i_wcr_wdata[`IAV_WCR_EN_BIT];
      wcr_q[6:3] <= 4'h0;
      if (i_wcr_wdata[`IAV_WCR_MASK_MSB:`IAV_WCR_MASK_LSB] > `IAV_WCR_MASK_MAX)
      begin
        wcr_q[`IAV_WCR_MASK_MSB:`IAV_WCR_MASK_LSB] <= `IAV_WCR_MASK_MAX;
      end
      else
      begin
        wcr_q[`IAV_WCR_MASK_MSB:`IAV_WCR_MASK_LSB] <=
          i_wcr_wdata[`IAV_WCR_MASK_MSB:`IAV_WCR_MASK_LSB];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wake_q <= 1'b0;
    end
    else
    begin
      wake_q <= wcr_q[`IAV_WCR_EN_BIT] &
        (level_d > wcr_q[`IAV_WCR_MASK_MSB:`IAV_WCR_MASK_LSB]); // R18
    end
  end

  // Previous encoded level and mask for edge detection
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      level_q <= `IAV_LEVEL_NONE;
      mask_q <= `IAV_LEVEL_NMI;
    end
    else
    begin
      level_q <= level_d; // R9 R13
      mask_q <= i_processor_mask_field;
    end
  end

  // Level seven is taken on its rising edge or on a mask drop from seven; one to six follow the mask
  always_comb
  begin
    nmi_event = ((level_d == `IAV_LEVEL_NMI) && (level_q != `IAV_LEVEL_NMI)) // R8 R9
      || ((level_d == `IAV_LEVEL_NMI) && (level_q == `IAV_LEVEL_NMI)
      && (mask_q == `IAV_LEVEL_NMI) && (i_processor_mask_field != `IAV_LEVEL_NMI)); // R10
    can_sample = !i_handler_first_instr; // R14
    take_d = 1'b0;
    nmi_state_d = nmi_state_q;
    case (nmi_state_q)
      iav_pkg::IAV_NMI_IDLE:
      begin
        if (nmi_event)
        begin
          nmi_state_d = iav_pkg::IAV_NMI_PENDING;
        end
      end
      iav_pkg::IAV_NMI_PENDING:
      begin
        if (can_sample)
        begin
          take_d = 1'b1;
          if (!nmi_event)
          begin
            nmi_state_d = iav_pkg::IAV_NMI_IDLE;
          end
        end
      end
      default:
      begin
        nmi_state_d = iav_pkg::IAV_NMI_IDLE;
      end
    endcase
    if (can_sample && (level_d != `IAV_LEVEL_NMI) && (level_d > i_processor_mask_field))
    begin
      take_d = 1'b1; // R8
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      nmi_state_q <= iav_pkg::IAV_NMI_IDLE;
      nmi_q <= 1'b0;
      take_q <= 1'b0;
    end
    else
    begin
      nmi_state_q <= nmi_state_d;
      nmi_q <= nmi_event; // R9 R10
      take_q <= take_d; // R14
    end
  end

  // Exception entry and store-load status side effects on the mask
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      load7_q <= 1'b0;
      saved_q <= 3'h0;
    end
    else
    begin
      load7_q <= i_exception_entry & i_auto_mask_on_exception_bit; // R15
      if (i_store_load_status_instr)
      begin
        saved_q <= i_processor_mask_field; // R17
      end
    end
  end

  assign o_ack_data = ack_data_q;
  assign o_ack_valid = ack_valid_q;
  assign o_irq_level = level_q;
  assign o_nmi = nmi_q;
  assign o_int_take = take_q;
  assign o_mask_load_seven = load7_q;
  assign o_saved_mask = saved_q;
  assign o_wakeup = wake_q;
  assign o_wakeup_control_reg = wcr_q;
  assign o_forced_request_reg = frc_q;

endmodule : iav_interrupt_ack_vectoring

// ### hdl/iav_pkg.sv
// Types of the interrupt acknowledge and vectoring block.
// Assumes nothing beyond the constants header.
package iav_pkg;

  typedef logic [6:0] iav_vec_t;
  typedef logic [2:0] iav_level_t;

  typedef enum logic [0:0] {
    IAV_NMI_IDLE,
    IAV_NMI_PENDING
  } iav_nmi_state_t;

endpackage : iav_pkg

// ### hdl/iav_regs.svh
// Constants of the interrupt acknowledge and vectoring block.
// Assumes a single 8-bit register data path and seven request levels.
`ifndef IAV_REGS_SVH
`define IAV_REGS_SVH

// Acknowledge register select codes
`define IAV_SEL_SOFTWARE 3'h0
`define IAV_SEL_LEVEL7 3'h7

// Acknowledge register fields
`define IAV_ACK_RSVD_BIT 7
`define IAV_ACK_VEC_MSB 6
`define IAV_ACK_VEC_LSB 0

// Vector values
`define IAV_VEC_SPURIOUS 7'h18
`define IAV_VEC_NONE 7'h00
`define IAV_VEC_FORCE_L7 7'h38
`define IAV_VEC_SRC_BASE 7'h40

// Wake-up control fields and reset values
`define IAV_WCR_EN_BIT 7
`define IAV_WCR_MASK_MSB 2
`define IAV_WCR_MASK_LSB 0
`define IAV_WCR_MASK_MAX 3'h6
`define IAV_WCR_RESET 8'h00
`define IAV_FRC_RESET 7'h00

// Levels
`define IAV_LEVEL_NMI 3'h7
`define IAV_LEVEL_NONE 3'h0

`endif

// ### tb/iav_ack_monitor.sv
// Checker of acknowledge, level and mask outputs of the vectoring block.
// Assumes binding to the top module; one clock domain.
module iav_ack_monitor
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [55:0] i_irq,
  input wire logic i_ack_rd,
  input wire logic [2:0] i_ack_sel,
  input wire logic i_iack_cycle,
  input wire logic i_exception_entry,
  input wire logic i_auto_mask_on_exception_bit,
  input wire logic i_store_load_status_instr,
  input wire logic [2:0] i_processor_mask_field,
  input wire logic [7:0] o_ack_data,
  input wire logic o_ack_valid,
  input wire logic [2:0] o_irq_level,
  input wire logic o_nmi,
  input wire logic o_mask_load_seven,
  input wire logic [2:0] o_saved_mask,
  input wire logic [6:0] o_forced_request_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  sequence s_closed;
    i_processor_mask_field == 3'h7 && o_irq_level == 3'h7;
  endsequence
  sequence s_drop;
    s_closed ##1 (i_processor_mask_field != 3'h7 && o_irq_level == 3'h7) ##1 o_irq_level == 3'h7;
  endsequence
  property p_answer;
    i_ack_rd |=> o_ack_valid;
  endproperty
  property p_rsvd;
    o_ack_valid |-> !o_ack_data[7];
  endproperty
  property p_spur;
    i_ack_rd && !i_iack_cycle && i_ack_sel == 3'h7 && i_irq[55:48] == 8'h00
      && !o_forced_request_reg[6] |=> o_ack_data == 8'h18;
  endproperty
  property p_nmi;
    $rose(o_irq_level == 3'h7) |-> o_nmi;
  endproperty
  property p_drop;
    s_drop |-> o_nmi;
  endproperty
  property p_mask7;
    1'b1 |=> o_mask_load_seven == $past(i_exception_entry && i_auto_mask_on_exception_bit);
  endproperty
  property p_save;
    i_store_load_status_instr |=> o_saved_mask == $past(i_processor_mask_field);
  endproperty
  property p_hold;
    o_ack_valid ##1 !(i_ack_rd || i_iack_cycle) |=> $stable(o_ack_data);
  endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  a_rsvd: assert property (p_rsvd) else $error("bit 7 set");
  a_spur: assert property (p_spur) else $error("no spurious vector");
  a_nmi: assert property (p_nmi) else $error("no nmi on level 7");
  a_drop: assert property (p_drop) else $error("no nmi on mask drop");
  a_mask7: assert property (p_mask7) else $error("mask load wrong");
  a_save: assert property (p_save) else $error("saved mask wrong");
  a_hold: assert property (p_hold) else $error("ack data changed");
endmodule : iav_ack_monitor

bind iav_interrupt_ack_vectoring iav_ack_monitor u_mon (.*);

// ### tb/iav_core_model.sv
// Processor core model: acknowledge cycles and status register mask.
// Assumes tasks are called on a falling edge of i_clk.
module iav_core_model
(
  input wire logic i_clk,
  output logic o_iack_cycle,
  output logic [2:0] o_iack_level,
  output logic [2:0] o_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_iack_cycle = 1'b0;
    o_iack_level = 3'h0;
    o_mask = 3'h0;
  end
  task automatic ack(input logic [2:0] lvl);
    o_iack_cycle = 1'b1;
    o_iack_level = lvl;
    @(negedge i_clk);
    o_iack_cycle = 1'b0;
    // Released level shows no stale value
    o_iack_level = ~lvl;
  endtask : ack
  task automatic mask(input bit closed);
    o_mask = closed ? 3'h7 : 3'h0;
  endtask : mask
endmodule : iav_core_model

// ### tb/tb_interrupt_ack_vectoring.sv
// Self-checking bench of the interrupt acknowledge and vectoring block.
// Assumes the core model drives acknowledge cycles and the mask.
module tb_interrupt_ack_vectoring;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rstn, i_wcr_wr, i_ack_rd, i_iack_cycle, i_ack_cycle_enable_bit;
  logic i_auto_mask_on_exception_bit, i_exception_entry, i_handler_first_instr;
  logic i_store_load_status_instr, o_ack_valid, o_nmi, o_int_take, o_mask_load_seven, o_wakeup;
  logic [55:0] i_irq;
  logic [6:0] i_frc_set, i_frc_clr, o_forced_request_reg, fq;
  logic [7:0] i_wcr_wdata, o_ack_data, o_wakeup_control_reg;
  logic [2:0] i_ack_sel, i_iack_level, i_processor_mask_field, o_irq_level, o_saved_mask;
  int err_total, total_checks;
  iav_interrupt_ack_vectoring dut (.*);
  iav_core_model core (.i_clk(i_clk), .o_iack_cycle(i_iack_cycle),
    .o_iack_level(i_iack_level), .o_mask(i_processor_mask_field));
  initial i_clk = 1'b0;
  always #2 i_clk = ~i_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task conclude;
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  function automatic logic [6:0] lv(input logic [2:0] l);
    lv = 7'h18;
    for (int p = 0; p < 8; p++)
      if (i_irq[(l - 1) * 8 + p] === 1'b1)
        lv = 7'h40 + 7'((l - 1) * 8 + p);
    if (fq[l - 1] === 1'b1)
      lv = 7'h38 + 7'(7 - l);
  endfunction : lv
  function automatic logic [6:0] ev(input logic [2:0] s);
    ev = 7'h00;
    if (s != 3'h0)
      ev = lv(s);
    else
      for (int l = 1; l < 8; l++)
        if (lv(3'(l)) != 7'h18)
          ev = lv(3'(l));
  endfunction : ev
  task automatic rd(input logic [2:0] s, input bit cyc);
    logic [7:0] e;
    e = {1'b0, ev(s)};
    if (cyc)
      core.ack(s);
    else
    begin
      i_ack_rd = 1'b1;
      i_ack_sel = s;
      @(negedge i_clk);
      i_ack_rd = 1'b0;
      i_ack_sel = ~s;
    end
    // Valid stands only in the cycle after the taking edge
    chk({7'h00, o_ack_valid}, {7'h00, !cyc || i_ack_cycle_enable_bit});
    if (o_ack_valid === 1'b1)
      chk(o_ack_data, e);
    @(negedge i_clk);
  endtask : rd
  initial
  begin
    {i_rstn, i_wcr_wr, i_ack_rd, i_ack_cycle_enable_bit, i_auto_mask_on_exception_bit} = '0;
    {i_exception_entry, i_handler_first_instr, i_store_load_status_instr} = '0;
    {i_irq, i_frc_set, i_frc_clr, i_wcr_wdata, i_ack_sel, fq} = '0;
    err_total = 0;
    total_checks = 0;
    void'($urandom(65));
    repeat (5) @(negedge i_clk);
    i_rstn = 1'b1;
    chk(o_wakeup_control_reg, 8'h00);
    chk({1'b0, o_forced_request_reg}, 8'h00);
    for (int n = 0; n < 80; n++)
    begin
      // Handler has cleared its source; a new set of requests arrives
      i_irq = 56'({$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom});
      i_frc_set = 7'($urandom & $urandom & $urandom);
      i_frc_clr = 7'($urandom);
      fq = (fq & ~i_frc_clr) | i_frc_set;
      @(negedge i_clk);
      {i_frc_set, i_frc_clr} = '0;
      i_ack_cycle_enable_bit = 1'($urandom);
      rd(3'(n), 1'($urandom));
    end
    i_irq = '0;
    i_frc_clr = 7'h7F;
    fq = '0;
    @(negedge i_clk);
    i_frc_clr = '0;
    repeat (3) @(negedge i_clk);
    i_irq[48] = 1'b1;
    @(negedge i_clk);
    chk({5'h00, o_irq_level}, 8'h07);
    chk({7'h00, o_nmi}, 8'h01);
    core.mask(1'b1);
    {i_exception_entry, i_auto_mask_on_exception_bit, i_store_load_status_instr} = 3'h7;
    @(negedge i_clk);
    {i_exception_entry, i_store_load_status_instr} = '0;
    chk({7'h00, o_mask_load_seven}, 8'h01);
    chk({5'h00, o_saved_mask}, 8'h07);
    chk({7'h00, o_int_take}, 8'h01);
    core.mask(1'b0);
    @(negedge i_clk);
    chk({7'h00, o_nmi}, 8'h01);
    i_wcr_wr = 1'b1;
    i_wcr_wdata = 8'h87;
    @(negedge i_clk);
    i_wcr_wr = 1'b0;
    chk(o_wakeup_control_reg, 8'h86);
    @(negedge i_clk);
    chk({7'h00, o_wakeup}, 8'h01);
    // New level seven edge while the handler's first instruction runs
    i_irq = '0;
    i_handler_first_instr = 1'b1;
    @(negedge i_clk);
    i_irq[48] = 1'b1;
    repeat (2) @(negedge i_clk);
    chk({7'h00, o_int_take}, 8'h00);
    i_handler_first_instr = 1'b0;
    @(negedge i_clk);
    chk({7'h00, o_int_take}, 8'h01);
    // Maskable level three against open and closed mask
    i_irq = 56'h00_0000_0001_0000;
    @(negedge i_clk);
    chk({5'h00, o_irq_level}, 8'h03);
    chk({7'h00, o_int_take}, 8'h01);
    core.mask(1'b1);
    @(negedge i_clk);
    chk({7'h00, o_int_take}, 8'h00);
    conclude;
  end
  initial
  begin
    #40000;
    err_total++;
    conclude;
  end
endmodule : tb_interrupt_ack_vectoring
